/* src/tmr_pulse_pkg.sv */
// Constants, field layouts and types shared by the pulse output timer channel
package tmr_pulse_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_TIMER_CONTROL = 10'h0_F1;
  localparam logic [9:0] IDX_RELOAD        = 10'h0_F2;
  localparam logic [9:0] IDX_PRESCALE      = 10'h0_F3;
  localparam logic [9:0] IDX_PORT_CONFIG   = 10'h0_F7;
  localparam logic [9:0] IDX_IRQ_MASK      = 10'h0_F8;
  localparam logic [9:0] IDX_IRQ_STATUS    = 10'h0_F9;
  localparam int         ADDR_LSB          = 2;
  localparam int         ADDR_MSB          = 11;

  // Field positions
  localparam int CTL_LOAD_BIT   = 2;
  localparam int CTL_ENABLE_BIT = 3;
  localparam int PRE_CONT_BIT   = 0;
  localparam int PRE_INT_BIT    = 1;
  localparam int PORT_LINE6_BIT = 5;
  localparam int IRQ_EOC_BIT    = 0;

  // Field codes
  localparam logic [1:0] OUT_SEL_THIS_TIMER = 2'h2;
  localparam logic [5:0] DIV_ZERO_CODE      = 6'h00;
  localparam logic [6:0] DIV_ZERO_VALUE     = 7'h40;
  localparam logic [7:0] COUNT_TERMINAL     = 8'h01;
  localparam logic [7:0] COUNT_DONE         = 8'h00;

  // Reset values
  localparam logic [7:0]  RST_TIMER_CONTROL = 8'h00;
  localparam logic [7:0]  RST_RELOAD        = 8'h00;
  localparam logic [7:0]  RST_PRESCALE      = 8'h00;
  localparam logic [7:0]  RST_PORT_CONFIG   = 8'h00;
  localparam logic [7:0]  RST_IRQ           = 8'h00;
  localparam logic [31:0] RDATA_ZERO        = 32'h0000_0000;

  // Timer control register layout
  typedef struct packed {
    logic [1:0] out_sel;
    logic [1:0] in_mode;
    logic       enable;
    logic       load;
    logic [1:0] other_timer;
  } timer_ctrl_t;

  // Prescale register layout
  typedef struct packed {
    logic [5:0] factor;
    logic       int_clk;
    logic       continuous;
  } prescale_t;

  // Counting state of the channel
  typedef enum logic {ST_STOP, ST_RUN} cnt_state_t;

endpackage

/* src/timer_pulse_output_toggle.sv */
// Down-counting pulse output timer channel with APB register access
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps

// Summary of operation
// R1: Reload writes never disturb the count already in progress.
// R2: Continuous mode reloads the newest reload value at end-of-count.
// R3: Load bit loads counter from reload and forces output high.
// R4: Reload writes without load bit leave the output level alone.
// R5: Output selected to this timer toggles at every end-of-count.
// R6: Every end-of-count sets the status bit; the interrupt request rises only while that bit is unmasked.
// R7: Software keeps one prescaler setting for long and short intervals.
// R8: Prescale bits 7:2 give division factor; zero divides by 64.
// R9: Prescale bit 1 selects the internal clock as count source.
// R10: Prescale bit 0 selects continuous mode; zero gives single pass.
// R11: Control bits 7:6 = 10 route toggle, bit 3 enables, bit 2 loads.
// R12: Port config bit 5 low makes line six the timer output.
// R13: Counter decrements per prescale pulse; end-of-count on leaving one.
module timer_pulse_output_toggle (
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RST_B_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Timer output pin, port three line six
  output logic             PORT_THREE_LINE_SIX_OUT,
  output logic             PORT_THREE_LINE_SIX_OE_OUT,
  // Interrupt
  output logic             SECOND_TIMER_IRQ_OUT
);

  // Register state
  tmr_pulse_pkg::timer_ctrl_t timer_control_reg_r;
  tmr_pulse_pkg::prescale_t   prescale_reg_r;
  logic                 [7:0] reload_r;
  logic                 [7:0] port_config_r;
  logic                 [7:0] irq_mask_r;
  logic                 [7:0] irq_status_r;
  logic                 [7:0] irq_status_nxt;

  // Counter state
  tmr_pulse_pkg::cnt_state_t  state_r;
  logic                 [7:0] count_r;
  logic                 [5:0] pre_cnt_r;
  logic                       tout_r;

  // Bus and event wires
  logic                       acc;
  logic                       done;
  logic                       wr;
  logic                       rd;
  logic                 [9:0] idx;
  logic                       mapped;
  logic                       load_req;
  logic                       tick;
  logic                       eoc;
  logic                       counting;
  logic                 [6:0] div_val;
  logic                [31:0] rdata_nxt;

  // Division factor, with the zero code standing for the largest divide
  function automatic logic [6:0] div_of(input logic [5:0] code);
    if (code == tmr_pulse_pkg::DIV_ZERO_CODE) begin
      div_of = tmr_pulse_pkg::DIV_ZERO_VALUE; // R8
    end else begin
      div_of = {1'b0, code};
    end
  endfunction

  // Decode a register index against the map
  function automatic logic is_mapped(input logic [9:0] i);
    case (i)
      tmr_pulse_pkg::IDX_TIMER_CONTROL,
      tmr_pulse_pkg::IDX_RELOAD,
      tmr_pulse_pkg::IDX_PRESCALE,
      tmr_pulse_pkg::IDX_PORT_CONFIG,
      tmr_pulse_pkg::IDX_IRQ_MASK,
      tmr_pulse_pkg::IDX_IRQ_STATUS: is_mapped = 1'b1;
      default:                       is_mapped = 1'b0;
    endcase
  endfunction

  // APB phase decode; one wait state, the access ends on the edge with ready high
  assign acc    = PSEL_IN & PENABLE_IN;
  assign done   = acc & PREADY_OUT;
  assign idx    = PADDR_IN[tmr_pulse_pkg::ADDR_MSB:tmr_pulse_pkg::ADDR_LSB];
  assign mapped = is_mapped(idx);
  assign wr     = done & PWRITE_IN & mapped;
  assign rd     = acc & ~PREADY_OUT & ~PWRITE_IN;

  // A control write with the load bit set triggers a load
  assign load_req = wr & (idx == tmr_pulse_pkg::IDX_TIMER_CONTROL) &
                    PWDATA_IN[tmr_pulse_pkg::CTL_LOAD_BIT]; // R3 R11

  // Counting only runs on the internal clock, when enabled and not finished
  assign counting = (state_r == tmr_pulse_pkg::ST_RUN) &
                    timer_control_reg_r.enable & // R11
                    prescale_reg_r.int_clk; // R9

  // One prescaler setting serves every interval of the channel
  assign div_val = div_of(prescale_reg_r.factor); // R7 R8

  // Prescale pulse when the divide counter reaches its last step
  assign tick = counting & ({1'b0, pre_cnt_r} == (div_val - 7'h01));

  // End-of-count when the counter leaves one; a reload of zero gives 256 steps
  assign eoc = tick & (count_r == tmr_pulse_pkg::COUNT_TERMINAL); // R13

  // APB ready and error; ready is held for exactly one access edge
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT  <= acc & ~PREADY_OUT;
      PSLVERR_OUT <= acc & ~PREADY_OUT & ~mapped;
    end
  end

  // Read data mux; the reload index reads back the live count
  always_comb begin
    rdata_nxt = tmr_pulse_pkg::RDATA_ZERO;
    case (idx)
      tmr_pulse_pkg::IDX_TIMER_CONTROL: begin
        rdata_nxt[7:0] = timer_control_reg_r;
      end
      tmr_pulse_pkg::IDX_RELOAD: begin
        rdata_nxt[7:0] = count_r;
      end
      tmr_pulse_pkg::IDX_PRESCALE: begin
        rdata_nxt[7:0] = prescale_reg_r;
      end
      tmr_pulse_pkg::IDX_PORT_CONFIG: begin
        rdata_nxt[7:0] = port_config_r;
      end
      tmr_pulse_pkg::IDX_IRQ_MASK: begin
        rdata_nxt[7:0] = irq_mask_r;
      end
      tmr_pulse_pkg::IDX_IRQ_STATUS: begin
        rdata_nxt[7:0] = irq_status_r;
      end
      default: begin
        rdata_nxt = tmr_pulse_pkg::RDATA_ZERO;
      end
    endcase
  end

  // Read data is captured in the first access cycle and held to completion
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PRDATA_OUT <= tmr_pulse_pkg::RDATA_ZERO;
    end else if (rd) begin
      PRDATA_OUT <= rdata_nxt;
    end else if (done) begin
      PRDATA_OUT <= tmr_pulse_pkg::RDATA_ZERO;
    end
  end

  // Timer control; the load bit is a trigger and never stays set
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      timer_control_reg_r <= tmr_pulse_pkg::RST_TIMER_CONTROL;
    end else if (wr && idx == tmr_pulse_pkg::IDX_TIMER_CONTROL) begin
      timer_control_reg_r      <= PWDATA_IN[7:0];
      timer_control_reg_r.load <= 1'b0;
    end
  end

  // Prescale register; a change mid-interval applies at once to the rest of that interval
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      prescale_reg_r <= tmr_pulse_pkg::RST_PRESCALE;
    end else if (wr && idx == tmr_pulse_pkg::IDX_PRESCALE) begin
      prescale_reg_r <= PWDATA_IN[7:0]; // R8 R9 R10
    end
  end

  // Reload register; stores only, the running count is left alone
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      reload_r <= tmr_pulse_pkg::RST_RELOAD;
    end else if (wr && idx == tmr_pulse_pkg::IDX_RELOAD) begin
      reload_r <= PWDATA_IN[7:0]; // R1
    end
  end

  // Port three configuration
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      port_config_r <= tmr_pulse_pkg::RST_PORT_CONFIG;
    end else if (wr && idx == tmr_pulse_pkg::IDX_PORT_CONFIG) begin
      port_config_r <= PWDATA_IN[7:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      irq_mask_r <= tmr_pulse_pkg::RST_IRQ;
    end else if (wr && idx == tmr_pulse_pkg::IDX_IRQ_MASK) begin
      irq_mask_r <= PWDATA_IN[7:0];
    end
  end

  // Sticky status: write one to clear, a new end-of-count wins over the clear
  always_comb begin
    irq_status_nxt = irq_status_r;
    if (wr && idx == tmr_pulse_pkg::IDX_IRQ_STATUS) begin
      irq_status_nxt = irq_status_r & ~PWDATA_IN[7:0];
    end
    if (eoc) begin
      irq_status_nxt[tmr_pulse_pkg::IRQ_EOC_BIT] = 1'b1; // R6
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      irq_status_r <= tmr_pulse_pkg::RST_IRQ;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  // Interrupt level follows the next status so it rises with the status bit
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      SECOND_TIMER_IRQ_OUT <= 1'b0;
    end else begin
      SECOND_TIMER_IRQ_OUT <= |(irq_status_nxt & irq_mask_r); // R6
    end
  end

  // Prescale divide counter; restarts on load so the first interval is whole
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pre_cnt_r <= 6'h00;
    end else if (load_req || tick) begin
      pre_cnt_r <= 6'h00;
    end else if (counting) begin
      pre_cnt_r <= pre_cnt_r + 6'h01;
    end
  end

  // Run state; a single pass stops at its end-of-count
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_r <= tmr_pulse_pkg::ST_STOP;
    end else begin
      case (state_r)
        tmr_pulse_pkg::ST_STOP: begin
          if (load_req) begin
            state_r <= tmr_pulse_pkg::ST_RUN; // R3
          end
        end
        tmr_pulse_pkg::ST_RUN: begin
          if (load_req) begin
            state_r <= tmr_pulse_pkg::ST_RUN;
          end else if (eoc && !prescale_reg_r.continuous) begin
            state_r <= tmr_pulse_pkg::ST_STOP; // R10
          end
        end
        default: begin
          state_r <= tmr_pulse_pkg::ST_STOP;
        end
      endcase
    end
  end

  // Down-counter; load takes priority, then reload or finish at end-of-count
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      count_r <= tmr_pulse_pkg::RST_RELOAD;
    end else if (load_req) begin
      count_r <= reload_r; // R3
    end else if (eoc) begin
      if (prescale_reg_r.continuous) begin
        count_r <= reload_r; // R2 R10
      end else begin
        count_r <= tmr_pulse_pkg::COUNT_DONE;
      end
    end else if (tick) begin
      count_r <= count_r - 8'h01; // R13
    end
  end

  // Timer output level; only load and end-of-count move it
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      tout_r <= 1'b0;
    end else if (load_req) begin
      tout_r <= 1'b1; // R3
    end else if (eoc && timer_control_reg_r.out_sel == tmr_pulse_pkg::OUT_SEL_THIS_TIMER) begin
      tout_r <= ~tout_r; // R5 R11
    end
  end

  // Pin drive; a reload write reaches neither flop here, so the level holds
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PORT_THREE_LINE_SIX_OUT    <= 1'b0;
      PORT_THREE_LINE_SIX_OE_OUT <= 1'b0;
    end else begin
      PORT_THREE_LINE_SIX_OUT    <= tout_r; // R4
      PORT_THREE_LINE_SIX_OE_OUT <= ~port_config_r[tmr_pulse_pkg::PORT_LINE6_BIT]; // R12
    end
  end

endmodule

/* sim/tpo_chk.sv */
// Concurrent checks on the ports of the pulse output timer
`timescale 1ns/10ps
module tpo_chk (
  // Clock, reset and APB
  input wire logic        CLK_IN,
  input wire logic        RST_B_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  // Pin and interrupt
  input wire logic        PORT_THREE_LINE_SIX_OUT,
  input wire logic        PORT_THREE_LINE_SIX_OE_OUT,
  input wire logic        SECOND_TIMER_IRQ_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // Completed write to one register index
  sequence s_wr(logic [9:0] ix);
    PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PADDR_IN[11:2] == ix;
  endsequence
  // Access phase opened by the master
  sequence s_open;
    PSEL_IN && $rose(PENABLE_IN);
  endsequence
  // Answer is one wait cycle after the access opens
  sequence s_answer;
    !PREADY_OUT ##1 PREADY_OUT;
  endsequence
  property p_rdy_wait; s_open |-> s_answer; endproperty
  property p_rdy_pulse; PREADY_OUT |=> !PREADY_OUT; endproperty
  property p_rdy_acc; PREADY_OUT |-> PSEL_IN && PENABLE_IN; endproperty
  property p_err; PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0000_0000; endproperty
  property p_hi_zero; PREADY_OUT |-> PRDATA_OUT[31:8] == 24'h00_0000; endproperty
  // Pin lags the internal level by one clock
  property p_load;
    s_wr(tmr_pulse_pkg::IDX_TIMER_CONTROL) ##0 PWDATA_IN[tmr_pulse_pkg::CTL_LOAD_BIT]
      |=> ##1 PORT_THREE_LINE_SIX_OUT;
  endproperty
  property p_oe;
    s_wr(tmr_pulse_pkg::IDX_PORT_CONFIG) ##0 !PWDATA_IN[tmr_pulse_pkg::PORT_LINE6_BIT]
      |-> ##[1:2] PORT_THREE_LINE_SIX_OE_OUT;
  endproperty
  property p_mask;
    s_wr(tmr_pulse_pkg::IDX_IRQ_MASK) ##0 !PWDATA_IN[0] |-> ##[1:2] !SECOND_TIMER_IRQ_OUT;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("late or early pready");
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
  a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside access");
  a_err: assert property (p_err) else $error("bad error response");
  a_hi_zero: assert property (p_hi_zero) else $error("read data upper bits set");
  a_load: assert property (p_load) else $error("load did not force pin high");
  a_oe: assert property (p_oe) else $error("pin not enabled as output");
  a_mask: assert property (p_mask) else $error("masked interrupt still high");
endmodule

/* sim/testbench.sv */
// Self-checking bench for the pulse output timer channel
`timescale 1ns/10ps
module testbench;
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [11:0] padr;
  logic [31:0] pwd;
  logic [31:0] prd;
  logic        rdy;
  logic        err;
  logic        pin;
  logic        oe;
  logic        irq;
  logic [31:0] rd;
  logic        re;
  int          fail_count = 0;
  int          checks = 0;
  int          seed = 32'haf98;
  int          q[$];
  int          dc;
  int          dv;
  // Control, reload, prescale, port, mask, status
  logic [9:0]  ix[6] = '{tmr_pulse_pkg::IDX_TIMER_CONTROL, tmr_pulse_pkg::IDX_RELOAD,
    tmr_pulse_pkg::IDX_PRESCALE, tmr_pulse_pkg::IDX_PORT_CONFIG,
    tmr_pulse_pkg::IDX_IRQ_MASK, tmr_pulse_pkg::IDX_IRQ_STATUS};

  timer_pulse_output_toggle i_timer_pulse_output_toggle (
    .CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
    .PREADY_OUT(rdy), .PSLVERR_OUT(err), .PORT_THREE_LINE_SIX_OUT(pin),
    .PORT_THREE_LINE_SIX_OE_OUT(oe), .SECOND_TIMER_IRQ_OUT(irq));

  // Free running clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One transfer; the request stands until pready is sampled high
  task apb(input logic w, input logic [9:0] a, input logic [7:0] v);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    padr <= {a, 2'b00};
    pwd  <= {24'h00_0000, v};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prd;
    re = err;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  // Clocks until the pin changes, sampled just after each edge
  task meas;
    int   c;
    logic v;
    c = 0;
    v = pin;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (pin === v && c < 20000);
    chk("interval", q.pop_front(), c);
  endtask

  // Hang guard, well beyond the longest run
  initial begin
    #400_000;
    fail_count++;
    end_of_test();
  end

  initial begin
    {rst_b, psel, pen, pwr, padr, pwd} = '0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    foreach (ix[i]) begin
      apb(1'b0, ix[i], 8'h00);
      chk("reset value", 32'h0000_0000, rd);
    end
    apb(1'b0, 10'h0_F4, 8'h00);
    chk("unmapped error", 32'h0000_0001, {31'h0, re});
    // Drive the pin away from the timer first, so the enable check can fail
    apb(1'b1, ix[3], 8'h20);
    @(posedge clk);
    #1;
    chk("pin disabled", 32'h0000_0000, {31'h0, oe});
    apb(1'b1, ix[3], 8'h00);
    @(posedge clk);
    #1;
    chk("pin enable", 32'h0000_0001, {31'h0, oe});
    $display("registers done");
    // Random divisor first, then the zero code that divides by 64
    for (int k = 0; k < 2; k++) begin
      dc = k ? 0 : 1 + $unsigned($random(seed)) % 5;
      dv = dc ? dc : 64;
      q = {dv * 8, dv * 20, dv * 20};
      apb(1'b1, ix[2], {dc[5:0], 2'b11});
      apb(1'b1, ix[1], 8'h08);
      apb(1'b1, ix[4], 8'h01);
      apb(1'b1, ix[0], 8'h8C);
      @(posedge clk);
      #1;
      chk("load level", 32'h0000_0001, {31'h0, pin});
      fork
        apb(1'b1, ix[1], 8'h14);
        meas();
      join
      fork
        meas();
        begin
          chk("irq raised", 32'h0000_0001, {31'h0, irq});
          apb(1'b0, ix[5], 8'h00);
          chk("status set", 32'h0000_0001, rd);
          apb(1'b1, ix[5], 8'h01);
          @(posedge clk);
          #1;
          chk("irq cleared", 32'h0000_0000, {31'h0, irq});
          apb(1'b1, ix[4], 8'h00);
        end
      join
      meas();
      chk("irq masked", 32'h0000_0000, {31'h0, irq});
      apb(1'b0, ix[5], 8'h00);
      chk("status sticky", 32'h0000_0001, rd);
      apb(1'b1, ix[4], 8'h01);
      @(posedge clk);
      #1;
      chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
      // Stop counting, then clear the status so the next run starts clean
      apb(1'b1, ix[0], 8'h00);
      apb(1'b1, ix[5], 8'h01);
      $display("continuous run %0d done", k);
    end
    // Single pass with the pin routed elsewhere
    apb(1'b1, ix[2], 8'h06);
    apb(1'b1, ix[1], 8'h0A);
    apb(1'b1, ix[0], 8'h4C);
    apb(1'b1, ix[5], 8'h01);
    repeat (30) @(posedge clk);
    #1;
    chk("pin held", 32'h0000_0001, {31'h0, pin});
    apb(1'b0, ix[1], 8'h00);
    chk("count stopped", 32'h0000_0000, rd);
    apb(1'b0, ix[5], 8'h00);
    chk("single eoc", 32'h0000_0001, rd);
    apb(1'b0, ix[0], 8'h00);
    chk("load bit clear", 32'h0000_0048, rd);
    // External count source selected: a load must leave the count standing
    apb(1'b1, ix[2], 8'h05);
    apb(1'b1, ix[0], 8'h8C);
    repeat (30) @(posedge clk);
    apb(1'b0, ix[1], 8'h00);
    chk("no internal clock", 32'h0000_000A, rd);
    $display("single pass done");
    end_of_test();
  end
endmodule

bind timer_pulse_output_toggle tpo_chk i_chk (
  .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .PORT_THREE_LINE_SIX_OUT(PORT_THREE_LINE_SIX_OUT),
  .PORT_THREE_LINE_SIX_OE_OUT(PORT_THREE_LINE_SIX_OE_OUT),
  .SECOND_TIMER_IRQ_OUT(SECOND_TIMER_IRQ_OUT));
